// file: design/tsp_cfg.svh
// Purpose: Offsets, field positions, reset values and fixed counts of the TDM serial port.
// Assumes: Byte addresses on an 8-bit register port with 32-bit data.
// Notes:   Definitions only.
`ifndef TSP_CFG_SVH
`define TSP_CFG_SVH

// Register byte addresses.
`define TSP_ADDR_CTRL   8'h00
`define TSP_ADDR_BPF    8'h04
`define TSP_ADDR_DIV    8'h08
`define TSP_ADDR_STAT   8'h0c
`define TSP_ADDR_SLOT   8'h10
`define TSP_ADDR_TX     8'h20
`define TSP_ADDR_RX     8'h30

// Control field positions.
`define TSP_CTRL_EN     0
`define TSP_CTRL_MASTER 1
`define TSP_CTRL_FRM_LO 2
`define TSP_CTRL_FRM_HI 3
`define TSP_CTRL_ALIGN  4
`define TSP_CTRL_EDGE   5
`define TSP_CTRL_LIN    6
`define TSP_CTRL_HALF   7
`define TSP_CTRL_REV    8
`define TSP_CTRL_LOOP   9

// Status field positions.
`define TSP_STAT_FLAG   0
`define TSP_STAT_RUN    1
`define TSP_STAT_FCNT   8

// Reset values.
`define TSP_CTRL_RST    10'h000
`define TSP_BPF_RST     4'h2
`define TSP_DIV_RST     16'h0004

// Bits in one stereo word.
`define TSP_WORD_BITS   11'h010

`endif

// file: design/tsp_pkg.sv
// Purpose: Types shared by the TDM serial port.
// Assumes: Nothing is imported; users write tsp_pkg::name.
// Notes:   The whole port state is one packed struct.
package tsp_pkg;

	typedef enum logic [1:0] {
		TSP_FRM_I2S = 2'b00,
		TSP_FRM_PCM = 2'b01,
		TSP_FRM_GCI = 2'b10,
		TSP_FRM_RSV = 2'b11
	} tsp_frm_t;

	typedef enum logic [0:0] {
		TSP_IDLE = 1'b0,
		TSP_RUN  = 1'b1
	} tsp_st_t;

	typedef struct packed {
		logic       hit;
		logic [1:0] ch;
		logic [4:0] idx;
		logic [7:0] slot;
	} tsp_sel_t;

	typedef struct packed {
		tsp_st_t          st;
		logic [9:0]       ctrl;
		logic [3:0]       bpfCode;
		logic [15:0]      div;
		logic [3:0][6:0]  slot;
		logic [3:0][31:0] tx;
		logic [3:0][31:0] rx;
		logic [3:0][31:0] rxWork;
		logic [9:0]       actCtrl;
		logic [10:0]      actBpf;
		logic [15:0]      actDiv;
		logic [3:0][6:0]  actSlot;
		logic             clkS1;
		logic             clkS2;
		logic             clkS3;
		logic             fsS1;
		logic             fsS2;
		logic             fsPrev;
		logic             dinS1;
		logic             dinS2;
		logic [15:0]      divCnt;
		logic             bclkOut;
		logic [10:0]      fcnt;
		logic             wsFs;
		logic             dout;
		logic [31:0]      rdata;
		logic             rxFlag;
		logic [7:0]       frameCnt;
	} tsp_state_t;

endpackage

// file: design/tsp_port.sv
// Purpose: Four-wire TDM audio serial port with stereo, timeslot and GCI-style framing.
// Assumes: mclk at 200 MHz; link pins are asynchronous and sampled by mclk.
// Notes:   Overview of operation follows.
// Overview of operation
// - Stereo framing runs at 8, 16 and 48 kHz frames, master or slave.
// - As stereo master, word select has 50% duty, left then right per frame.
// - Bits per frame programmable: 8,16,32,64,96,128,192,256,384,512,1024.
// - Stereo words travel most significant bit first.
// - Input bits after a word's last bit are discarded.
// - Standard alignment: left with select low, MSB one bit after transition.
// - Left-justified: left with select high, MSB at the transition edge.
// - Master drives bit clock and select; slave takes both as inputs.
// - Each channel gets its own programmable 8-bit timeslot.
// - Timeslots carry 8-bit companded or 16-bit linear samples.
// - One rate and one encoding apply to all channels of the port.
// - A 16-bit sample uses slot N and slot N+1.
// - Sub-band ADPCM at 8 kHz uses one 8-bit slot per channel.
// - Half-frame wideband adds a second pair at N plus bits-per-frame/16.
// - Timeslot and GCI master frame sync lasts one bit period.
// - Timeslot and GCI slave accepts frame sync pulses of any width.
// - Edge select (timeslot framing only): 0 launches data on falling, 1 on rising bit clock; stereo and GCI launch on falling.
// - GCI-style: one clock per bit, voice in any slot, no side channels.
// - GCI-style first data bit coincides with the frame sync rising edge.
// - Up to four bidirectional channels, each mapped to any slot.
// - Optional bit-order reversal and internal loopback.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "tsp_cfg.svh"

module tsp_port (
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        srst,
	// Register port.
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdata,
	// Bit clock pin.
	input  wire logic        bitClockIn,
	output logic             bitClockOut,
	output logic             bitClockOeN,
	// Frame sync or word select pin.
	input  wire logic        frameSyncIn,
	output logic             frameSyncOut,
	output logic             frameSyncOeN,
	// Serial data pins.
	input  wire logic        serialDataIn,
	output logic             serialDataOut
);

	tsp_pkg::tsp_state_t state_q;
	tsp_pkg::tsp_state_t state_d;
	tsp_pkg::tsp_frm_t   frm;
	tsp_pkg::tsp_sel_t   selL;
	tsp_pkg::tsp_sel_t   selC;
	logic                run;
	logic                isMaster;
	logic                isI2s;
	logic                isPcm;
	logic                edgeSel;
	logic                leftLvl;
	logic                genToggle;
	logic                bitRise;
	logic                bitFall;
	logic                launchEv;
	logic                captEv;
	logic                lastBit;
	logic                wsNext;
	logic                txBit;
	logic                rxBit;
	logic                msbBit;
	logic [10:0]         nextF;
	logic [10:0]         halfBpf;
	logic [10:0]         fsPos;
	logic [7:0]          relC;
	logic [7:0]          halfSlots;
	logic [31:0]         rdNext;

	// Maps a frame size code to bits per frame.
	function automatic logic [10:0] bpfValue(input logic [3:0] code);
		case (code)
			4'h0: bpfValue = 11'h008;
			4'h1: bpfValue = 11'h010;
			4'h2: bpfValue = 11'h020;
			4'h3: bpfValue = 11'h040;
			4'h4: bpfValue = 11'h060;
			4'h5: bpfValue = 11'h080;
			4'h6: bpfValue = 11'h0c0;
			4'h7: bpfValue = 11'h100;
			4'h8: bpfValue = 11'h180;
			4'h9: bpfValue = 11'h200;
			default: bpfValue = 11'h400;
		endcase
	endfunction

	// True when an address falls in a bank of four word registers.
	function automatic logic inBank(input logic [7:0] addr, input logic [7:0] base);
		inBank = (addr[7:4] == base[7:4]) && (addr[1:0] == 2'h0);
	endfunction

	// Finds the channel and word bit that a frame position carries.
	function automatic tsp_pkg::tsp_sel_t bitSel(
		input logic [9:0]      c,
		input logic [10:0]     bpf,
		input logic [3:0][6:0] sl,
		input logic [10:0]     pos
	);
		tsp_pkg::tsp_sel_t s;
		logic [10:0] half;
		logic [10:0] hp;
		logic [10:0] k;
		logic [10:0] p;
		logic [7:0]  rel;
		logic [7:0]  rel2;
		logic [7:0]  hs;
		logic [7:0]  w;
		logic [4:0]  nb;
		logic [4:0]  kk;
		logic [4:0]  bi;
		logic        dly;
		logic        lin;
		int          i;
		s    = '0;
		half = bpf >> 1;
		hs   = {1'b0, bpf[10:4]};
		lin  = c[`TSP_CTRL_LIN];
		nb   = lin ? 5'h10 : 5'h08;
		w    = lin ? 8'h02 : 8'h01;
		if (c[`TSP_CTRL_FRM_HI:`TSP_CTRL_FRM_LO] == tsp_pkg::TSP_FRM_I2S) begin
			dly  = !c[`TSP_CTRL_ALIGN];
			hp   = (pos < half) ? pos : pos - half;
			s.ch = (pos < half) ? 2'h0 : 2'h1;
			k    = hp - {10'h000, dly};
			// Positions past the word carry nothing and are ignored on input.
			if ((hp >= {10'h000, dly}) && (k < `TSP_WORD_BITS)) begin
				s.hit = 1'b1;
				s.idx = c[`TSP_CTRL_REV] ? k[4:0] : 5'h0f - k[4:0];
			end
		end else begin
			// Timeslot framing starts two bits after sync rises, the frame's last bit between; GCI at the sync edge.
			dly    = (c[`TSP_CTRL_FRM_HI:`TSP_CTRL_FRM_LO] == tsp_pkg::TSP_FRM_PCM);
			p      = (dly && (pos == 11'h000)) ? bpf - 11'h001 : pos - {10'h000, dly};
			s.slot = p[10:3];
			for (i = 3; i >= 0; i--) begin
				rel  = s.slot - {1'b0, sl[i]};
				rel2 = rel - hs;
				kk   = lin ? {1'b0, rel[0], p[2:0]} : {2'h0, p[2:0]};
				bi   = c[`TSP_CTRL_REV] ? kk : nb - 5'h01 - kk;
				// A linear sample spans slots N and N+1.
				if (rel < w) begin
					s.hit = 1'b1;
					s.ch  = i[1:0];
					s.idx = {1'b0, bi[3:0]};
				end else if (c[`TSP_CTRL_HALF] && (rel2 < w)) begin
					// Half-frame wideband adds a pair half a frame later.
					s.hit = 1'b1;
					s.ch  = i[1:0];
					s.idx = {1'b1, bi[3:0]};
				end
			end
		end
		bitSel = s;
	endfunction

	// Decoded view of the active configuration.
	assign frm      = tsp_pkg::tsp_frm_t'(state_q.actCtrl[`TSP_CTRL_FRM_HI:`TSP_CTRL_FRM_LO]);
	assign run      = (state_q.st == tsp_pkg::TSP_RUN);
	assign isMaster = state_q.actCtrl[`TSP_CTRL_MASTER];
	assign isI2s    = (frm == tsp_pkg::TSP_FRM_I2S);
	assign isPcm    = (frm == tsp_pkg::TSP_FRM_PCM);
	assign edgeSel  = isPcm && state_q.actCtrl[`TSP_CTRL_EDGE];
	assign leftLvl  = state_q.actCtrl[`TSP_CTRL_ALIGN];
	assign halfBpf  = state_q.actBpf >> 1;
	assign halfSlots = {1'b0, state_q.actBpf[10:4]};
	assign fsPos    = isPcm ? state_q.actBpf - 11'h001 : 11'h000;

	// Bit clock events from the divider as master or the sampled pin as slave.
	assign genToggle = run && isMaster &&
		(({1'b0, state_q.divCnt} + 17'h00001) >= {1'b0, state_q.actDiv});
	assign bitRise  = isMaster ? genToggle && !state_q.bclkOut : state_q.clkS2 && !state_q.clkS3;
	assign bitFall  = isMaster ? genToggle && state_q.bclkOut : !state_q.clkS2 && state_q.clkS3;
	assign launchEv = run && (edgeSel ? bitRise : bitFall);
	assign captEv   = run && (edgeSel ? bitFall : bitRise);

	// Frame position, pin values and bit selection for the coming edges.
	assign lastBit = (state_q.fcnt == state_q.actBpf - 11'h001);
	assign nextF   = lastBit ? 11'h000 : state_q.fcnt + 11'h001;
	assign wsNext  = isI2s ? ((nextF < halfBpf) ? leftLvl : !leftLvl) : (nextF == fsPos);
	assign selL    = bitSel(state_q.actCtrl, state_q.actBpf, state_q.actSlot, nextF);
	assign selC    = bitSel(state_q.actCtrl, state_q.actBpf, state_q.actSlot, state_q.fcnt);
	assign txBit   = selL.hit ? state_q.tx[selL.ch][selL.idx] : 1'b0;
	assign msbBit  = state_q.tx[selL.ch][15];
	assign rxBit   = state_q.actCtrl[`TSP_CTRL_LOOP] ? state_q.dout : state_q.dinS2;
	assign relC    = selC.slot - {1'b0, state_q.actSlot[selC.ch]};

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rdNext = 32'h0000_0000;
		if (regAddr == `TSP_ADDR_CTRL) begin
			rdNext = {22'h000000, state_q.ctrl};
		end else if (regAddr == `TSP_ADDR_BPF) begin
			rdNext = {28'h0000000, state_q.bpfCode};
		end else if (regAddr == `TSP_ADDR_DIV) begin
			rdNext = {16'h0000, state_q.div};
		end else if (regAddr == `TSP_ADDR_STAT) begin
			rdNext = {16'h0000, state_q.frameCnt, 6'h00, run, state_q.rxFlag};
		end else if (inBank(regAddr, `TSP_ADDR_SLOT)) begin
			rdNext = {25'h0000000, state_q.slot[regAddr[3:2]]};
		end else if (inBank(regAddr, `TSP_ADDR_TX)) begin
			rdNext = state_q.tx[regAddr[3:2]];
		end else if (inBank(regAddr, `TSP_ADDR_RX)) begin
			rdNext = state_q.rx[regAddr[3:2]];
		end
	end

	// Next state of the whole port.
	always_comb begin
		state_d       = state_q;
		state_d.clkS1 = bitClockIn;
		state_d.clkS2 = state_q.clkS1;
		state_d.clkS3 = state_q.clkS2;
		state_d.fsS1  = frameSyncIn;
		state_d.fsS2  = state_q.fsS1;
		state_d.dinS1 = serialDataIn;
		state_d.dinS2 = state_q.dinS1;
		state_d.rdata = regRead ? rdNext : 32'h0000_0000;
		if (regWrite) begin
			if (regAddr == `TSP_ADDR_CTRL) begin
				state_d.ctrl = regWdata[9:0];
			end else if (regAddr == `TSP_ADDR_BPF) begin
				state_d.bpfCode = regWdata[3:0];
			end else if (regAddr == `TSP_ADDR_DIV) begin
				state_d.div = regWdata[15:0];
			end else if (inBank(regAddr, `TSP_ADDR_SLOT)) begin
				state_d.slot[regAddr[3:2]] = regWdata[6:0];
			end else if (inBank(regAddr, `TSP_ADDR_TX)) begin
				state_d.tx[regAddr[3:2]] = regWdata;
			end
		end
		// Reading status clears the frame flag; a frame end in that cycle wins.
		if (regRead && (regAddr == `TSP_ADDR_STAT)) begin
			state_d.rxFlag = 1'b0;
		end
		case (state_q.st)
			tsp_pkg::TSP_IDLE: begin
				state_d.fcnt    = 11'h000;
				state_d.divCnt  = 16'h0000;
				state_d.bclkOut = 1'b0;
				state_d.wsFs    = 1'b0;
				state_d.dout    = 1'b0;
				state_d.fsPrev  = state_q.fsS2;
				state_d.actCtrl = state_q.ctrl;
				state_d.actBpf  = bpfValue(state_q.bpfCode);
				state_d.actDiv  = state_q.div;
				state_d.actSlot = state_q.slot;
				if (state_q.ctrl[`TSP_CTRL_EN]) begin
					state_d.st = tsp_pkg::TSP_RUN;
				end
			end
			tsp_pkg::TSP_RUN: begin
				if (!state_q.ctrl[`TSP_CTRL_EN]) begin
					state_d.st = tsp_pkg::TSP_IDLE;
				end
				// Integer divider makes the bit clock as master.
				if (isMaster) begin
					state_d.divCnt = genToggle ? 16'h0000 : state_q.divCnt + 16'h0001;
					if (genToggle) begin
						state_d.bclkOut = !state_q.bclkOut;
					end
				end
				// Launch edge: advance position, drive data and sync.
				if (launchEv) begin
					state_d.fcnt = nextF;
					state_d.dout = txBit;
					state_d.wsFs = wsNext;
					if (nextF == 11'h000) begin
						state_d.actCtrl  = state_q.ctrl;
						state_d.actBpf   = bpfValue(state_q.bpfCode);
						state_d.actDiv   = state_q.div;
						state_d.actSlot  = state_q.slot;
						state_d.rx       = state_q.rxWork;
						state_d.rxFlag   = 1'b1;
						state_d.frameCnt = state_q.frameCnt + 8'h01;
					end
				end
				// Capture edge: store input bits and lock a slave to the sync pin.
				if (captEv) begin
					if (selC.hit) begin
						state_d.rxWork[selC.ch][selC.idx] = rxBit;
					end
					state_d.fsPrev = state_q.fsS2;
					if (!isMaster && isI2s && (state_q.fsS2 != state_q.fsPrev)) begin
						state_d.fcnt = (state_q.fsS2 == leftLvl) ? 11'h000 : halfBpf;
					end else if (!isMaster && !isI2s && state_q.fsS2 && !state_q.fsPrev) begin
						state_d.fcnt = fsPos;
					end
				end
			end
			default: begin
				state_d.st = tsp_pkg::TSP_IDLE;
			end
		endcase
	end

	// State register with synchronous reset.
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q         <= '0;
			state_q.st      <= tsp_pkg::TSP_IDLE;
			state_q.ctrl    <= `TSP_CTRL_RST;
			state_q.bpfCode <= `TSP_BPF_RST;
			state_q.div     <= `TSP_DIV_RST;
		end else begin
			state_q <= state_d;
		end
	end

	// Pin and register port outputs; enables are low while driving.
	assign regRdata      = state_q.rdata;
	assign bitClockOut   = state_q.bclkOut;
	assign frameSyncOut  = state_q.wsFs;
	assign serialDataOut = state_q.dout;
	assign bitClockOeN   = !(run && isMaster);
	assign frameSyncOeN  = !(run && isMaster);

	// Checks on framing, timing and register behaviour.
	a_ws_duty: assert property (@(posedge mclk) disable iff (srst)
		launchEv && isI2s && isMaster && ((nextF == halfBpf) || (nextF == 11'h000))
		|=> (state_q.wsFs != $past(state_q.wsFs)))
		else $error("word select did not toggle at half frame");

	a_fs_width: assert property (@(posedge mclk) disable iff (srst)
		launchEv && !isI2s && isMaster && state_q.wsFs && (state_q.actBpf > 11'h001)
		|=> !state_q.wsFs)
		else $error("frame sync longer than one bit period");

	a_frame_wrap: assert property (@(posedge mclk) disable iff (srst)
		launchEv && lastBit |=> (state_q.fcnt == 11'h000))
		else $error("frame position did not wrap at bits per frame");

	a_cfg_boundary: assert property (@(posedge mclk) disable iff (srst)
		run && $past(run) && $changed(state_q.actCtrl) |-> (state_q.fcnt == 11'h000))
		else $error("configuration changed inside a frame");

	a_clock_divide: assert property (@(posedge mclk) disable iff (srst)
		run && $past(run) && $changed(state_q.bclkOut) |-> $past(genToggle))
		else $error("bit clock toggled off the divider count");

	a_rx_discard: assert property (@(posedge mclk) disable iff (srst)
		captEv && !selC.hit |=> $stable(state_q.rxWork))
		else $error("bit outside a word was stored");

	a_slot_pair: assert property (@(posedge mclk) disable iff (srst)
		captEv && !isI2s && !state_q.actCtrl[`TSP_CTRL_HALF] && selC.hit
		|-> (relC < 8'h02))
		else $error("capture outside slots N and N+1");

	a_half_pair: assert property (@(posedge mclk) disable iff (srst)
		captEv && !isI2s && state_q.actCtrl[`TSP_CTRL_HALF] && selC.hit && selC.idx[4]
		|-> ((relC - halfSlots) < 8'h02))
		else $error("second pair not half a frame after the first");

	a_msb_first: assert property (@(posedge mclk) disable iff (srst)
		launchEv && isI2s && !state_q.actCtrl[`TSP_CTRL_REV] && selL.hit && (selL.idx == 5'h0f)
		|=> (serialDataOut == $past(msbBit)))
		else $error("stereo word did not start with its top bit");

	a_read_data: assert property (@(posedge mclk) disable iff (srst)
		regRead && (regAddr == `TSP_ADDR_CTRL) |=> (regRdata == {22'h000000, $past(state_q.ctrl)}))
		else $error("control read data wrong");

endmodule

// file: test/tsp_codec_model.sv
// Purpose: Behavioural far-side stereo codec for the TDM serial port bench.
// Assumes: Stereo framing; the bench resolves the shared clock and select wires.
// Notes:   Can be clock master at a 48 ns bit period or follow the port's clocks.
`timescale 1ns/1ps

module tsp_codec_model #(
	parameter int HALF_BITS = 16
) (
	// Link wires as resolved by the bench.
	input  wire logic        bitClk,
	input  wire logic        wsIn,
	input  wire logic        dutOut,
	// Mode and words to send.
	input  wire logic        isMaster,
	input  wire logic        lj,
	input  wire logic [15:0] txLeft,
	input  wire logic [15:0] txRight,
	// Driven pins and captured words.
	output logic             bclkDrv,
	output logic             wsDrv,
	output logic             sdi,
	output logic [15:0]      capLeft,
	output logic [15:0]      capRight
);
	int          cnt;
	int          gen;
	int          kc;
	int          kn;
	logic        wsR;
	logic [15:0] sh;

	// As master the bit clock runs without pause; select toggles on a falling edge.
	initial begin
		bclkDrv = 1'b0;
		wsDrv = 1'b0;
		sdi = 1'b0;
		capLeft = '0;
		capRight = '0;
		cnt = 0;
		gen = 0;
		wsR = 1'b0;
		sh = '0;
		#1.3;
		forever begin
			#24;
			if (isMaster) begin
				bclkDrv = ~bclkDrv;
				if (!bclkDrv) begin
					gen++;
					if (gen == HALF_BITS) begin
						gen = 0;
						wsDrv = ~wsDrv;
					end
				end
			end else begin
				bclkDrv = 1'b0;
			end
		end
	end

	// Capture on rising edges; the bit position restarts at every select change.
	always @(posedge bitClk) begin
		cnt = (wsIn !== wsR) ? 0 : cnt + 1;
		wsR = wsIn;
		kc = lj ? cnt : cnt - 1;
		if (kc >= 0 && kc < 16) begin
			sh = {sh[14:0], dutOut};
			if (kc == 15 && (lj ? wsIn : !wsIn)) begin
				capLeft = sh;
			end else if (kc == 15) begin
				capRight = sh;
			end
		end
	end

	// Launch after each falling edge, once a select change on that edge has settled.
	always @(negedge bitClk) begin
		#1;
		kn = (wsIn !== wsR) ? 0 : cnt + 1;
		kn = lj ? kn : kn - 1;
		if (kn >= 0 && kn < 16 && !$isunknown(wsIn)) begin
			sdi = (lj ? wsIn : !wsIn) ? txLeft[15 - kn] : txRight[15 - kn];
		end else begin
			sdi = ~sdi;
		end
	end
endmodule

// file: test/tsp_port_tb.sv
// Purpose: Self-checking bench for the TDM serial port.
// Assumes: 200 MHz mclk; the codec model stands on the link pins.
// Notes:   A monitor checks each read against a queue of expected values.
`timescale 1ns/1ps
`include "tsp_cfg.svh"

module tsp_port_tb;
	logic        mclk, srst, regWrite, regRead, rdPend;
	logic [7:0]  regAddr;
	logic [31:0] regWdata, regRdata, expV, mskV;
	logic        bitClockOut, bitClockOeN, frameSyncOut, frameSyncOeN, serialDataOut;
	logic        bclkDrv, wsDrv, sdi, isMaster, lj;
	logic [15:0] txL, txR, capL, capR, seed;
	logic [31:0] tx [4];
	logic [31:0] rdQ [$];
	logic [31:0] mkQ [$];
	int          error_cnt, checked;
	// Each shared wire follows whichever side has its driver enabled.
	wire         bitClk = bitClockOeN ? bclkDrv : bitClockOut;
	wire         ws = frameSyncOeN ? wsDrv : frameSyncOut;

	tsp_port u_dut (
		.mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.bitClockIn(bitClk), .bitClockOut(bitClockOut), .bitClockOeN(bitClockOeN),
		.frameSyncIn(ws), .frameSyncOut(frameSyncOut), .frameSyncOeN(frameSyncOeN),
		.serialDataIn(sdi), .serialDataOut(serialDataOut));

	tsp_codec_model #(.HALF_BITS(16)) u_codec (
		.bitClk(bitClk), .wsIn(ws), .dutOut(serialDataOut), .isMaster(isMaster), .lj(lj),
		.txLeft(txL), .txRight(txR), .bclkDrv(bclkDrv), .wsDrv(wsDrv), .sdi(sdi),
		.capLeft(capL), .capRight(capR));

	// Clock generator.
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Compares one value and counts the outcome.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Register cycles; each starts just after an edge so strobes may run back to back.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		regRead <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		regAddr <= a;
		regRead <= 1'b1;
		regWrite <= 1'b0;
		rdQ.push_back(e);
		mkQ.push_back(m);
		@(posedge mclk);
	endtask

	task automatic idle();
		regWrite <= 1'b0;
		regRead <= 1'b0;
		@(posedge mclk);
	endtask

	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction

	// Waits for n rises of the frame sync wire under a cycle bound.
	task automatic waitFrames(input int n);
		int seen = 0;
		int c = 0;
		logic wp;
		wp = ws;
		while (seen < n) begin
			@(posedge mclk);
			c++;
			if (ws && !wp) begin
				seen++;
			end
			wp = ws;
			if (c > 5000 * n) begin
				error_cnt++;
				results();
			end
		end
	endtask

	// Times one frame: bit clock rises and cycles with the sync line high.
	task automatic measure(input int bits, input int high);
		int nb = 0;
		int nh = 1;
		int c = 0;
		logic bp;
		logic wp;
		// The first frame after enable starts part-way, so the second one is timed.
		waitFrames(2);
		bp = bitClk;
		wp = ws;
		repeat (5000) begin
			@(posedge mclk);
			// A bit clock rise in the closing sample still belongs to this frame.
			nb += int'(bitClk && !bp);
			bp = bitClk;
			if (ws && !wp) break;
			nh += int'(ws);
			wp = ws;
			c++;
		end
		if (c == 5000) begin
			error_cnt++;
			results();
		end
		check(32'(nb), 32'(bits));
		check(32'(nh), 32'(high));
	endtask

	// One stereo run: words both ways, then the read-back of what arrived.
	task automatic stereoRun(input logic [9:0] c, input logic [3:0] code, input logic ljm,
		input logic mst);
		logic [15:0] a;
		logic [15:0] b;
		a = rnd();
		b = rnd();
		txL <= rnd();
		txR <= rnd();
		lj <= ljm;
		isMaster <= !mst;
		wr(`TSP_ADDR_CTRL, 32'h0);
		wr(`TSP_ADDR_BPF, {28'h0, code});
		// Four mclk per half bit leave room for the two-stage input synchroniser.
		wr(`TSP_ADDR_DIV, 32'h4);
		wr(`TSP_ADDR_TX, {rnd(), a});
		wr(`TSP_ADDR_TX + 8'h04, {rnd(), b});
		wr(`TSP_ADDR_CTRL, {22'h0, c});
		idle();
		waitFrames(6);
		check(32'(bitClockOeN), 32'(!mst));
		check(32'(frameSyncOeN), 32'(!mst));
		check({16'h0, capL}, {16'h0, a});
		check({16'h0, capR}, {16'h0, b});
		// The port runs, and frame ends have set the flag since status was last read.
		rd(`TSP_ADDR_STAT, 32'h3, 32'h3);
		rd(`TSP_ADDR_RX, {16'h0, txL}, 32'hffff);
		rd(`TSP_ADDR_RX + 8'h04, {16'h0, txR}, 32'hffff);
		idle();
	endtask

	// Read monitor: the data stand in the cycle after the strobe.
	always @(posedge mclk) begin
		if (rdPend) begin
			expV = rdQ.pop_front();
			mskV = mkQ.pop_front();
			check(regRdata & mskV, expV & mskV);
		end
		rdPend <= regRead;
	end

	task automatic results();
		if (error_cnt == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		static int bpfTab [11] = '{8, 16, 32, 64, 96, 128, 192, 256, 384, 512, 1024};
		static logic [9:0] cfg [6] = '{10'h207, 10'h227, 10'h247, 10'h2c7, 10'h347, 10'h24b};
		static logic [31:0] msk [6] =
			'{32'hff, 32'hff, 32'hffff, 32'hffffffff, 32'hffff, 32'hffff};
		srst = 1'b1;
		regAddr = '0;
		regWdata = '0;
		regWrite = 1'b0;
		regRead = 1'b0;
		rdPend = 1'b0;
		isMaster = 1'b0;
		lj = 1'b1;
		txL = '0;
		txR = '0;
		seed = 16'h0035;
		error_cnt = 0;
		checked = 0;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		// Reset values, read-only and unmapped places, field widths.
		rd(`TSP_ADDR_CTRL, 32'h0, 32'hffffffff);
		rd(`TSP_ADDR_BPF, 32'h2, 32'hffffffff);
		rd(`TSP_ADDR_DIV, 32'h4, 32'hffffffff);
		rd(8'h40, 32'h0, 32'hffffffff);
		wr(`TSP_ADDR_RX, 32'hffffffff);
		wr(`TSP_ADDR_STAT, 32'hffffffff);
		wr(`TSP_ADDR_BPF, 32'hfffffff5);
		wr(`TSP_ADDR_DIV, 32'hffff0003);
		wr(`TSP_ADDR_SLOT, 32'hffffff85);
		rd(`TSP_ADDR_RX, 32'h0, 32'hffffffff);
		rd(`TSP_ADDR_STAT, 32'h0, 32'hffffffff);
		rd(`TSP_ADDR_BPF, 32'h5, 32'hffffffff);
		rd(`TSP_ADDR_DIV, 32'h3, 32'hffffffff);
		rd(`TSP_ADDR_SLOT, 32'h5, 32'hffffffff);
		idle();
		// Every frame length as stereo master, one mclk per half bit.
		for (int i = 0; i < 11; i++) begin
			wr(`TSP_ADDR_CTRL, 32'h0);
			wr(`TSP_ADDR_BPF, 32'(i));
			wr(`TSP_ADDR_DIV, 32'h1);
			wr(`TSP_ADDR_CTRL, 32'h13);
			idle();
			measure(bpfTab[i], bpfTab[i]);
		end
		stereoRun(10'h013, 4'h2, 1'b1, 1'b1);
		stereoRun(10'h003, 4'h3, 1'b0, 1'b1);
		stereoRun(10'h011, 4'h2, 1'b1, 1'b0);
		isMaster <= 1'b0;
		// Timeslot and GCI-style modes on internal loopback, four channels.
		for (int i = 0; i < 6; i++) begin
			wr(`TSP_ADDR_CTRL, 32'h0);
			wr(`TSP_ADDR_BPF, 32'h5);
			wr(`TSP_ADDR_DIV, 32'h1);
			for (int ch = 0; ch < 4; ch++) begin
				tx[ch] = {rnd(), rnd()};
				// Programmed slots stay clear of the last slot; only channel 3's half-frame pair reaches it.
				wr(`TSP_ADDR_SLOT + 8'(4 * ch), 32'(2 * ch));
				wr(`TSP_ADDR_TX + 8'(4 * ch), tx[ch]);
			end
			wr(`TSP_ADDR_CTRL, {22'h0, cfg[i]});
			idle();
			measure(128, 2);
			waitFrames(2);
			for (int ch = 0; ch < 4; ch++) begin
				rd(`TSP_ADDR_RX + 8'(4 * ch), tx[ch], msk[i]);
			end
			idle();
		end
		results();
	end
endmodule
